// ### logic/daisy_pkg.sv
// Constants and types for the cascaded converter serial port and power-down control
//
// Summary of operation
// - Serial output of each converter feeds the next cascade input; the last feeds the host.
// - After 16 result bits, the 17th shift clock shows the cascade input bit.
// - Serial output at read end equals cascade input present at read start.
// - With two devices, 17th clock puts upstream MSB on downstream output.
// - Analog sleep powers analog parts off except reference; stored result stays readable.
// - A conversion during analog sleep is meaningless and is flagged invalid.
// - Both sleeps: all analog off; result kept unless already shifted out.
// - Digital logic, registers and shifting keep working in every sleep state.
// - Reference sleep turns off only the reference; reference buffer stays on.
// - Output drives only with chip select low and read/convert high; select high means external clock.
// - External mode: MSB on 1st rising edge, LSB 16th, first cascade bit 17th.
package daisy_pkg;
    localparam int          WORD_BITS        = 16;
    localparam int          CNT_W            = 5;
    localparam logic [4:0]  TAG_COUNT        = 5'h10;
    localparam logic [4:0]  CNT_MAX          = 5'h1F;
    localparam logic [4:0]  INT_CLOCKS       = 5'h11;
    localparam int          ADDR_W           = 12;
    localparam logic [11:0] OFF_CTRL         = 12'h000;
    localparam logic [11:0] OFF_STATUS       = 12'h004;
    localparam logic [11:0] OFF_RESULT       = 12'h008;
    localparam int          CTRL_LOAD_EN     = 0;
    localparam logic        CTRL_LOAD_RESET  = 1'b1;
    localparam int          ST_LOADED        = 0;
    localparam int          ST_INVALID       = 1;
    localparam int          ST_ASLEEP        = 2;
    localparam int          ST_RSLEEP        = 3;
    localparam int          ST_CNT_LSB       = 4;
    localparam int          CLK_PERIOD_NS    = 5;
    localparam int          INT_CLK_NS       = 96;
    localparam int          INT_HALF_RAW     = INT_CLK_NS / (2 * CLK_PERIOD_NS);
    localparam logic [4:0]  INT_HALF_CYC     = 5'(INT_HALF_RAW < 1 ? 1 : INT_HALF_RAW);
    localparam int          PIN_CLK          = 0;
    localparam int          PIN_TAG          = 1;
    localparam int          PIN_CS_N         = 2;
    localparam int          PIN_RC           = 3;
    localparam int          PIN_EXT          = 4;
    localparam int          PIN_ASLEEP       = 5;
    localparam int          PIN_RSLEEP       = 6;
    localparam int          PIN_COUNT        = 7;

    typedef enum logic [2:0]
    {
        SH_EMPTY  = 3'h1,
        SH_LOADED = 3'h2,
        SH_SHIFT  = 3'h4
    } shift_state_t;
endpackage

// ### logic/word_stream_if.sv
// Valid/ready word carrier between the buffer and the shifter
`timescale 1ns/100ps
`default_nettype none
interface word_stream_if;
    logic [15:0] data;
    logic        valid;
    logic        ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ### logic/pin_sync.sv
// Two-flop synchronisers with edge detection for the pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int W = 7
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Pins and synchronised view
    input  wire logic [W-1:0] pins,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end
        else
        begin
            meta_ff <= pins;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    generate
        for (genvar i = 0; i < W; i++)
        begin : g_edge
            assign rise[i] = sync_ff[i] & ~prev_ff[i];
            assign fall[i] = ~sync_ff[i] & prev_ff[i];
        end
    endgenerate
    assign level = sync_ff;
endmodule // pin_sync
`default_nettype wire

// ### logic/word_buffer.sv
// Two-entry result buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module word_buffer (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Fill side
    input  wire logic [15:0]  in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // Drain side
    word_stream_if.src        out
);
    logic [15:0] mem [2];
    logic        wr_ptr_ff;
    logic        rd_ptr_ff;
    logic [1:0]  count_ff;
    logic        push;
    logic        pop;

    assign in_ready  = (count_ff != 2'h2);
    assign out.valid = (count_ff != 2'h0);
    assign out.data  = mem[rd_ptr_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out.valid & out.ready;

    always_ff @(posedge pclk)
    begin
        if (push)
            mem[wr_ptr_ff] <= in_data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff  <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= ~wr_ptr_ff;
            if (pop)
                rd_ptr_ff <= ~rd_ptr_ff;
            count_ff <= 2'(count_ff + {1'b0, push} - {1'b0, pop});
        end
    end
endmodule // word_buffer
`default_nettype wire

// ### logic/adc_daisy_chain_and_powerdown.sv
// Cascadable serial result port with power-down control and APB registers
`timescale 1ns/100ps
`default_nettype none
module adc_daisy_chain_and_powerdown (
    // APB slave
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [daisy_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Conversion results from the converter core
    input  wire logic [15:0]                  conv_data,
    input  wire logic                         conv_valid,
    output logic                              conv_ready,
    // Serial pins
    input  wire logic                         shift_clock_in,
    output logic                              shift_clock_out,
    output logic                              shift_clock_oe_n,
    input  wire logic                         cascade_in,
    output logic                              serial_result_out,
    output logic                              serial_result_oe_n,
    input  wire logic                         chip_select_n,
    input  wire logic                         read_convert,
    input  wire logic                         ext_clock_select,
    // Power-down pins and analog enables
    input  wire logic                         analog_sleep,
    input  wire logic                         reference_sleep,
    output logic                              analog_power_on,
    output logic                              reference_power_on,
    output logic                              ref_buffer_power_on
);
    import daisy_pkg::*;

    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] pin_lvl;
    logic [PIN_COUNT-1:0] pin_rise;
    logic [PIN_COUNT-1:0] pin_fall;
    word_stream_if        drain ();

    logic                 ext_mode;
    logic                 asleep;
    logic                 rsleep;
    logic                 read_open;
    logic                 frame;
    logic                 rise_evt;
    logic                 load_fire;
    logic                 drop_fire;
    logic                 int_rise;
    logic                 int_fall;
    logic                 set_invalid;
    logic                 clr_invalid;
    logic                 setup_phase;
    logic                 wr_fire;

    shift_state_t         state_ff;
    shift_state_t         nxt_state;
    logic [15:0]          shifter_ff;
    logic                 out_bit_ff;
    logic [CNT_W-1:0]     bit_cnt_ff;
    logic [15:0]          result_ff;
    logic                 invalid_ff;
    logic                 load_en_ff;
    logic                 int_active_ff;
    logic                 int_level_ff;
    logic [4:0]           int_div_ff;
    logic [CNT_W-1:0]     int_cnt_ff;
    logic                 a_on_ff;
    logic                 r_on_ff;
    logic                 b_on_ff;
    logic [31:0]          prdata_ff;
    logic                 pslverr_ff;
    logic [31:0]          rd_word;
    logic                 rd_hit;

    assign pins[PIN_CLK]    = shift_clock_in;
    assign pins[PIN_TAG]    = cascade_in;
    assign pins[PIN_CS_N]   = chip_select_n;
    assign pins[PIN_RC]     = read_convert;
    assign pins[PIN_EXT]    = ext_clock_select;
    assign pins[PIN_ASLEEP] = analog_sleep;
    assign pins[PIN_RSLEEP] = reference_sleep;

    pin_sync #(.W(PIN_COUNT)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    (pins),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // Results wait here while a read is under way
    word_buffer u_buf (
        .pclk     (pclk),
        .presetn  (presetn),
        .in_data  (conv_data),
        .in_valid (conv_valid),
        .in_ready (conv_ready),
        .out      (drain)
    );

    assign ext_mode  = pin_lvl[PIN_EXT];
    assign asleep    = pin_lvl[PIN_ASLEEP];
    assign rsleep    = pin_lvl[PIN_RSLEEP];
    assign read_open = ~pin_lvl[PIN_CS_N] & pin_lvl[PIN_RC];
    assign frame     = ext_mode ? read_open : int_active_ff;
    // Host edges outside an open read are ignored so stray clocks cannot eat data
    assign rise_evt  = ext_mode ? (pin_rise[PIN_CLK] & read_open) : int_rise;

    // Load only into an empty shifter: nothing corrupted mid-read, nothing lost unread except words drained during analog sleep
    assign drain.ready = load_en_ff & ~frame & (state_ff == SH_EMPTY);
    assign load_fire   = drain.valid & drain.ready & ~asleep;
    assign drop_fire   = drain.valid & drain.ready & asleep;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            SH_EMPTY:
                if (load_fire)
                    nxt_state = SH_LOADED;
            SH_LOADED:
                if (rise_evt)
                    nxt_state = SH_SHIFT;
            SH_SHIFT:
                // Shifted data are gone; nothing is kept for a second read
                if (!frame)
                    nxt_state = SH_EMPTY;
            default:
                nxt_state = SH_EMPTY;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= SH_EMPTY;
        else
            state_ff <= nxt_state;
    end

    // Shifter keeps running whatever the sleep inputs say
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shifter_ff <= 16'h0000;
            out_bit_ff <= 1'b0;
            bit_cnt_ff <= 5'h00;
        end
        else if (load_fire)
        begin
            shifter_ff <= drain.data;
            bit_cnt_ff <= 5'h00;
        end
        else if (rise_evt)
        begin
            out_bit_ff <= shifter_ff[WORD_BITS-1];
            shifter_ff <= {shifter_ff[WORD_BITS-2:0], pin_lvl[PIN_TAG]};
            if (bit_cnt_ff != CNT_MAX)
                bit_cnt_ff <= 5'(bit_cnt_ff + 5'h01);
        end
    end

    // Last loaded word stays readable over the register port
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_ff <= 16'h0000;
        else if (load_fire)
            result_ff <= drain.data;
    end

    // Internal clock mode: device makes its own shift clock for one word plus tag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_active_ff <= 1'b0;
            int_level_ff  <= 1'b0;
            int_div_ff    <= 5'h00;
            int_cnt_ff    <= 5'h00;
        end
        else if (load_fire && !ext_mode)
        begin
            int_active_ff <= 1'b1;
            int_level_ff  <= 1'b0;
            int_div_ff    <= 5'h00;
            int_cnt_ff    <= 5'h00;
        end
        else if (int_active_ff)
        begin
            if (int_div_ff == INT_HALF_CYC - 5'h01)
            begin
                int_div_ff   <= 5'h00;
                int_level_ff <= ~int_level_ff;
                if (int_level_ff && int_cnt_ff == INT_CLOCKS)
                    int_active_ff <= 1'b0;
            end
            else
            begin
                int_div_ff <= 5'(int_div_ff + 5'h01);
            end
            if (int_rise)
                int_cnt_ff <= 5'(int_cnt_ff + 5'h01);
        end
    end

    assign int_rise = int_active_ff & ~int_level_ff & (int_div_ff == INT_HALF_CYC - 5'h01);
    assign int_fall = int_active_ff & int_level_ff & (int_div_ff == INT_HALF_CYC - 5'h01);

    assign shift_clock_out    = int_level_ff;
    assign shift_clock_oe_n   = ext_mode;
    assign serial_result_out  = out_bit_ff;
    assign serial_result_oe_n = ~read_open;

    // Power enables: reference and its buffer are handled separately
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_on_ff <= 1'b0;
            r_on_ff <= 1'b0;
            b_on_ff <= 1'b0;
        end
        else
        begin
            a_on_ff <= ~asleep;
            r_on_ff <= ~rsleep;
            b_on_ff <= ~asleep;
        end
    end

    assign analog_power_on     = a_on_ff;
    assign reference_power_on  = r_on_ff;
    assign ref_buffer_power_on = b_on_ff;

    // APB slave, zero wait states
    assign setup_phase = psel & ~penable;
    assign wr_fire     = psel & penable & pwrite;
    assign pready      = psel & penable;
    assign prdata      = prdata_ff;
    assign pslverr     = pslverr_ff;
    assign set_invalid = drop_fire;
    assign clr_invalid = wr_fire & (paddr == OFF_STATUS) & pwdata[ST_INVALID];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            load_en_ff <= CTRL_LOAD_RESET;
        else if (wr_fire && paddr == OFF_CTRL)
            load_en_ff <= pwdata[CTRL_LOAD_EN];
    end

    // Set beats a simultaneous clear so no invalid conversion goes unseen
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            invalid_ff <= 1'b0;
        else if (set_invalid)
            invalid_ff <= 1'b1;
        else if (clr_invalid)
            invalid_ff <= 1'b0;
    end

    always_comb
    begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case (paddr)
            OFF_CTRL:
                rd_word[CTRL_LOAD_EN] = load_en_ff;
            OFF_STATUS:
            begin
                rd_word[ST_LOADED]  = (state_ff == SH_LOADED);
                rd_word[ST_INVALID] = invalid_ff;
                rd_word[ST_ASLEEP]  = asleep;
                rd_word[ST_RSLEEP]  = rsleep;
                rd_word[ST_CNT_LSB +: CNT_W] = bit_cnt_ff;
            end
            OFF_RESULT:
                rd_word[WORD_BITS-1:0] = result_ff;
            default:
                rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata_ff  <= pwrite ? 32'h00000000 : rd_word;
            pslverr_ff <= ~rd_hit;
        end
    end

    // Checking helpers
    logic       first_tag_ff;
    logic [15:0] loaded_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_tag_ff <= 1'b0;
            loaded_ff    <= 16'h0000;
        end
        else
        begin
            if (load_fire)
                loaded_ff <= drain.data;
            if (rise_evt && !load_fire && bit_cnt_ff == 5'h00)
                first_tag_ff <= pin_lvl[PIN_TAG];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_first_edge;
        rise_evt && !load_fire && bit_cnt_ff == 5'h00;
    endsequence
    sequence s_tag_edge;
        rise_evt && !load_fire && bit_cnt_ff == TAG_COUNT;
    endsequence

    a_msb_first_out: assert property (s_first_edge |=> out_bit_ff == loaded_ff[15])
        else $error("first shift edge did not present the MSB");
    a_tag_after_word: assert property (s_tag_edge |=> out_bit_ff == first_tag_ff)
        else $error("17th shift edge did not present the first cascade bit");
    a_read_end_tag: assert property (s_tag_edge ##1 !rise_evt |-> out_bit_ff == first_tag_ff)
        else $error("output after read differs from starting cascade level");
    a_cascade_shift_in: assert property (rise_evt && !load_fire |=> shifter_ff[0] == $past(pin_lvl[PIN_TAG]))
        else $error("cascade input not sampled on rising shift edge");
    a_drive_window: assert property (serial_result_oe_n == !(~pin_lvl[PIN_CS_N] && pin_lvl[PIN_RC]))
        else $error("serial output enabled outside an open read");
    a_sleep_no_load: assert property (drain.valid && drain.ready && asleep |=> invalid_ff && $stable(result_ff))
        else $error("conversion during analog sleep was loaded or not flagged");
    a_sleep_keeps_word: assert property (asleep && !rise_evt && !load_fire |=> $stable(shifter_ff))
        else $error("stored result changed during analog sleep without shifting");
    a_sleep_shifts_on: assert property (asleep && rise_evt && !load_fire |=> bit_cnt_ff != $past(bit_cnt_ff) || bit_cnt_ff == CNT_MAX)
        else $error("shifting stopped during sleep");
    a_ref_only_sleep: assert property (rsleep && !asleep ##1 rsleep && !asleep |-> !reference_power_on && ref_buffer_power_on && analog_power_on)
        else $error("reference sleep affected more than the reference");
    a_full_sleep_off: assert property (asleep && rsleep ##1 asleep && rsleep |-> !analog_power_on && !reference_power_on && !ref_buffer_power_on)
        else $error("analog parts still on in full sleep");
    a_invalid_set_wins: assert property (set_invalid && clr_invalid |=> invalid_ff)
        else $error("clear overrode a simultaneous invalid event");
endmodule // adc_daisy_chain_and_powerdown
`default_nettype wire

// ### verif/host_model.sv
// Host model: external shift clock, frame control and cascade source
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Serial link
    output logic      shift_clock,
    output logic      cascade_bit,
    output logic      chip_select_n,
    output logic      read_convert,
    output logic      ext_clock_select,
    input  wire logic serial_result_out,
    input  wire logic serial_result_oe_n
);
    logic [31:0] rx;
    logic        oe_ok;
    initial
    begin
        shift_clock = 1'b0;
        cascade_bit = 1'b0;
        // Every pin low until the interface supply is taken as steady
        chip_select_n = 1'b0;
        read_convert = 1'b0;
        ext_clock_select = 1'b0;
    end
    task automatic set_pins(input logic ext, input logic tag_level);
        chip_select_n = 1'b1;
        ext_clock_select = ext;
        cascade_bit = tag_level;
    endtask
    // Clock stands still outside frames; 32 rises show result then cascade word
    task automatic read_frame(input logic [15:0] tag);
        int k;
        oe_ok = 1'b1;
        chip_select_n = 1'b0;
        read_convert = 1'b1;
        #40;
        for (k = 0; k < 32; k++)
        begin
            // Beyond the tag word the line toggles, so a stale value cannot match
            cascade_bit = (k < 16) ? tag[15-k] : ~cascade_bit;
            #32 shift_clock = 1'b1;
            #32 rx = {rx[30:0], serial_result_out};
            oe_ok &= (serial_result_oe_n === 1'b0);
            shift_clock = 1'b0;
        end
        #32 chip_select_n = 1'b1;
        read_convert = 1'b0;
        cascade_bit = ~cascade_bit;
        #40;
    endtask
endmodule // host_model
`default_nettype wire

// ### verif/adc_daisy_chain_and_powerdown_test.sv
// Self-checking bench for the cascaded serial port and power-down block
`timescale 1ns/100ps
`default_nettype none
module adc_daisy_chain_and_powerdown_test;
    import daisy_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [15:0]       conv_data;
    logic              conv_valid, conv_ready, sclk, sclk_out, sclk_oe_n, tag, sdo, sdo_oe_n;
    logic              cs_n, rc, ext_sel, a_sleep, r_sleep, a_on, r_on, b_on;
    int                num_errors, checks_done, int_rises;

    adc_daisy_chain_and_powerdown u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_data(conv_data), .conv_valid(conv_valid),
        .conv_ready(conv_ready), .shift_clock_in(sclk), .shift_clock_out(sclk_out),
        .shift_clock_oe_n(sclk_oe_n), .cascade_in(tag), .serial_result_out(sdo),
        .serial_result_oe_n(sdo_oe_n), .chip_select_n(cs_n), .read_convert(rc),
        .ext_clock_select(ext_sel), .analog_sleep(a_sleep), .reference_sleep(r_sleep),
        .analog_power_on(a_on), .reference_power_on(r_on), .ref_buffer_power_on(b_on));
    host_model u_host (.shift_clock(sclk), .cascade_bit(tag), .chip_select_n(cs_n),
        .read_convert(rc), .ext_clock_select(ext_sel), .serial_result_out(sdo),
        .serial_result_oe_n(sdo_oe_n));

    always #2.5 pclk = ~pclk;
    always @(posedge sclk_out) int_rises++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Holds the request until pready is seen high, then takes data there
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic push(input logic [15:0] w);
        conv_data <= w;
        conv_valid <= 1'b1;
        do @(posedge pclk); while (conv_ready !== 1'b1);
        conv_valid <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic frame(input logic [15:0] t, input logic [31:0] exp);
        u_host.read_frame(t);
        check(u_host.rx, exp);
        check(32'(u_host.oe_ok), 32'h1);
        check(32'(sdo_oe_n), 32'h1);
        repeat (4) @(posedge pclk);
    endtask
    task automatic power(input logic [2:0] exp);
        repeat (5) @(posedge pclk);
        check(32'({a_on, r_on, b_on}), 32'(exp));
    endtask

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, conv_valid, a_sleep, r_sleep} = 8'h00;
        {paddr, pwdata, conv_data} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        u_host.set_pins(1'b1, 1'b0);
        power(3'h7);
        check(32'({sclk_oe_n, sdo_oe_n}), 32'h3);
        apb(1'b0, OFF_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0);
        check(rd & 32'hF, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0);
        check({rd[30:0], err}, 32'h1);
        push(16'hA5C3);
        repeat (4) @(posedge pclk);
        apb(1'b0, OFF_RESULT, 32'h0);
        check(rd, 32'hA5C3);
        frame(16'h3C96, 32'hA5C33C96);
        // Reference asleep: conversions and shifting still work
        r_sleep <= 1'b1;
        power(3'h5);
        push(16'h0FF0);
        repeat (4) @(posedge pclk);
        frame(16'h8001, 32'h0FF08001);
        a_sleep <= 1'b1;
        power(3'h0);
        push(16'h1234);
        repeat (4) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        check(rd & 32'hF, 32'hE);
        apb(1'b0, OFF_RESULT, 32'h0);
        check(rd, 32'h0FF0);
        r_sleep <= 1'b0;
        power(3'h2);
        apb(1'b1, OFF_STATUS, 32'h2);
        apb(1'b0, OFF_STATUS, 32'h0);
        check(rd & 32'h2, 32'h0);
        a_sleep <= 1'b0;
        // No analog settling is modelled; only the return of power is awaited
        power(3'h7);
        // Loading held off: buffer fills until it refuses, then drains
        apb(1'b1, OFF_CTRL, 32'h0);
        push(16'h1111);
        push(16'h2222);
        repeat (2) @(posedge pclk);
        check(32'(conv_ready), 32'h0);
        apb(1'b1, OFF_CTRL, 32'h1);
        repeat (4) @(posedge pclk);
        frame(16'h0000, 32'h11110000);
        frame(16'hFFFF, 32'h2222FFFF);
        check(32'(conv_ready), 32'h1);
        // Internal clock: 16 result bits, then the held cascade level
        u_host.set_pins(1'b0, 1'b1);
        repeat (4) @(posedge pclk);
        check(32'({sclk_oe_n, sdo_oe_n}), 32'h1);
        push(16'hFFFE);
        repeat (400) @(posedge pclk);
        check(32'(int_rises), 32'h11);
        check(32'(sdo), 32'h1);
        apb(1'b0, OFF_STATUS, 32'h0);
        check(rd & 32'h1FF, 32'h110);
        stop_test();
    end
    initial
    begin
        #60000;
        num_errors++;
        stop_test();
    end
endmodule // adc_daisy_chain_and_powerdown_test
`default_nettype wire
